/* File: hw/bmmd_regs.svh */
`ifndef BMMD_REGS_SVH
`define BMMD_REGS_SVH

// memory index order inside every 4-bit select vector
`define BMMD_MEM_PFLASH 0
`define BMMD_MEM_DFLASH 1
`define BMMD_MEM_ROM 2
`define BMMD_MEM_RAM 3

// decoder register window, 256 bytes
`define BMMD_DEC_WIN 24'hFF_FFFE
`define BMMD_OFS_CTRL 8'h00
`define BMMD_OFS_STAT 8'h04
`define BMMD_OFS_VERDICT 8'h08
`define BMMD_OFS_PERM 8'h0C
`define BMMD_OFS_ERASE 8'h10
`define BMMD_OFS_REGION 8'h20

// control fields
`define BMMD_CTRL_REMAP 0
`define BMMD_CTRL_RSTSEL 1
`define BMMD_ERASE_ALL 0
`define BMMD_ERASE_PAGE_LSB 8

// region size codes: window is 1 kB shifted left by the code
`define BMMD_SZ_2K 4'h1
`define BMMD_SZ_4K 4'h2
`define BMMD_SZ_32K 4'h5
`define BMMD_SZ_64K 4'h6
`define BMMD_SZ_MAX 4'hE

// reset and remap bases
`define BMMD_ROM_BASE_BOOT 32'h0000_0000
`define BMMD_ROM_BASE_RUN 32'h0001_0000
`define BMMD_PFL_BASE_BOOT 32'h0001_0000
`define BMMD_PFL_BASE_RUN 32'h0000_0000
`define BMMD_DFL_BASE 32'h0001_8800
`define BMMD_RAM_BASE 32'h0001_9000
`define BMMD_PERM_RESET 5'h1F

// peripheral windows
`define BMMD_AFE_FIRST 4'h2
`define BMMD_AFE_LAST 4'hE
`define BMMD_SYSPER_HI 19'h7_FFBF

// array geometry
`define BMMD_PFL_WORDS 8192
`define BMMD_DFL_WORDS 512
`define BMMD_RAM_WORDS 1024
`define BMMD_ROM_BYTES 4096
`define BMMD_PFL_PAGE_BYTES 1024
`define BMMD_DFL_PAGE_BYTES 32

`endif

/* File: hw/bmmd_pkg.sv */
package bmmd_pkg;

   typedef enum logic [2:0] {
      AC_IDLE = 3'b001,
      AC_ACCESS = 3'b010,
      AC_DONE = 3'b100
   } bmmd_acc_t;

   typedef enum logic [3:0] {
      BS_CHK_HEAD = 4'b0001,
      BS_CHK_FULL = 4'b0010,
      BS_RUN_FLASH = 4'b0100,
      BS_SERVICE = 4'b1000
   } bmmd_boot_t;

endpackage : bmmd_pkg

/* File: hw/bmmd_region_match.sv */
`timescale 1ns/1ps
`include "bmmd_regs.svh"
module bmmd_region_match (
   // access address
   input wire logic [31:0] addr,
   // region setting
   input wire logic [21:0] base,
   input wire logic [3:0] size,
   // result
   output logic hit,
   output logic [23:0] offset
);
   logic [21:0] lo_mask;
   logic [33:0] byte_mask;

   // size above 16 MB is clamped so a bad code cannot swallow the map
   always_comb begin
      lo_mask = (22'h1 << ((size > `BMMD_SZ_MAX) ? `BMMD_SZ_MAX : size)) - 22'h1;
      byte_mask = {2'b00, lo_mask, 10'h3FF};
      hit = ((addr[31:10] ^ base) & ~lo_mask) == 22'h0;
      offset = addr[23:0] & byte_mask[23:0];
   end
endmodule : bmmd_region_match

/* File: hw/bmmd_boot_seq.sv */
`timescale 1ns/1ps
module bmmd_boot_seq (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // checksum verdict from boot code
   input wire logic verdict_we,
   input wire logic verdict_pass,
   // state out
   output bmmd_pkg::bmmd_boot_t boot_state,
   output logic remap_pulse
);
   bmmd_pkg::bmmd_boot_t state_reg;
   bmmd_pkg::bmmd_boot_t state_next;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         bmmd_pkg::BS_CHK_HEAD: begin
            if (verdict_we) begin
               state_next = verdict_pass ? bmmd_pkg::BS_RUN_FLASH : bmmd_pkg::BS_CHK_FULL; // see RULE6
            end
         end
         bmmd_pkg::BS_CHK_FULL: begin
            if (verdict_we) begin
               state_next = verdict_pass ? bmmd_pkg::BS_RUN_FLASH : bmmd_pkg::BS_SERVICE; // see RULE7
            end
         end
         bmmd_pkg::BS_RUN_FLASH: state_next = bmmd_pkg::BS_RUN_FLASH;
         bmmd_pkg::BS_SERVICE: state_next = bmmd_pkg::BS_SERVICE; // see RULE8
         default: state_next = bmmd_pkg::BS_CHK_HEAD;
      endcase
   end

   // every reset restarts in the rom checks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= bmmd_pkg::BS_CHK_HEAD; // see RULE19
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign boot_state = state_reg;
   assign remap_pulse = ce && (state_reg != bmmd_pkg::BS_RUN_FLASH) && (state_next == bmmd_pkg::BS_RUN_FLASH);

   a_fail_twice_service : assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
      (ce && verdict_we && !verdict_pass && state_reg == bmmd_pkg::BS_CHK_FULL) |=> state_reg == bmmd_pkg::BS_SERVICE)
      else $error("second checksum failure did not enter service");
   c_service_entry : cover property (@(posedge clk) disable iff (sys_rst) state_reg == bmmd_pkg::BS_SERVICE);
endmodule : bmmd_boot_seq

/* File: hw/bmmd_decoder.sv */
// Notes on behaviour
// RULE1: all arrays and peripherals on one bus
// RULE2: after reset rom aliased over low 64 KB
// RULE3: boot map flash, data flash, ram bases
// RULE4: remap puts program flash at zero
// RULE5: front-end peripherals in 256-byte windows
// RULE6: reset starts rom, head checksum, then flash
// RULE7: head fails: full checksum decides flash start
// RULE8: both fail: rom serves host commands
// RULE9: service mode reaches every memory location
// RULE10: programmable region selects, 1 kB to 16 MB
// RULE11: decoder register access adds wait state
// RULE12: decoder registers ignore user-mode writes
// RULE13: stretch peripheral cycles, eight 1 kB selects
// RULE14: per-region user permissions enforced
// RULE15: illegal access gives fault or reset
// RULE16: program flash 8k x 32, page/mass erase
// RULE17: data flash 512 x 32 with ecc
// RULE18: data ram is 1k x 32
// RULE19: boot rom 4 kB runs first after reset
// RULE20: region changes apply from next access
`timescale 1ns/1ps
`include "bmmd_regs.svh"
module bmmd_decoder #(
   parameter int NUM_AFE = 13,
   parameter int NUM_PER = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // processor bus
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_priv,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic [31:0] cpu_rdata,
   output logic cpu_ready,
   output logic cpu_abort,
   // slave side
   output logic [3:0] mem_sel,
   output logic [NUM_AFE-1:0] afe_sel,
   output logic [NUM_PER-1:0] per_sel,
   output logic [23:0] slave_addr,
   output logic slave_we,
   output logic [31:0] slave_wdata,
   input wire logic slave_ready,
   input wire logic [31:0] slave_rdata,
   input wire logic dflash_ecc_err,
   // program flash erase
   output logic pflash_erase_req,
   output logic pflash_erase_all,
   output logic [4:0] pflash_erase_page,
   // system
   output logic sys_reset_req,
   output logic remap,
   output logic boot_service
);
   localparam int PFL_PAGES = `BMMD_PFL_WORDS * 4 / `BMMD_PFL_PAGE_BYTES;
   localparam int PAGE_W = $clog2(PFL_PAGES);

   ////////////////////////////////////////////////////////////////////////////
   // configuration state
   logic [21:0] base_reg [4];
   logic [3:0] size_reg [4];
   logic remap_reg;
   logic rstsel_reg;
   logic [4:0] perm_reg;
   bmmd_pkg::bmmd_boot_t boot_state;
   logic remap_pulse;
   logic verdict_we;
   logic cfg_we;

   ////////////////////////////////////////////////////////////////////////////
   // access state
   bmmd_pkg::bmmd_acc_t acc_reg;
   logic [3:0] acc_mem_reg;
   logic [NUM_AFE-1:0] acc_afe_reg;
   logic [NUM_PER-1:0] acc_per_reg;
   logic acc_dec_reg;
   logic acc_err_reg;
   logic acc_we_reg;
   logic acc_priv_reg;
   logic [7:0] acc_reg_ofs_reg;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic [3:0] mem_hit;
   logic [23:0] mem_ofs [4];
   logic [3:0] mem_win;
   logic [NUM_AFE-1:0] afe_hit;
   logic [NUM_PER-1:0] per_hit;
   logic dec_hit;
   logic [23:0] win_ofs;
   logic any_hit;
   logic perm_bad;
   logic service;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_region
         bmmd_region_match u_match (
            .addr(cpu_addr),
            .base(base_reg[gi]),
            .size(size_reg[gi]),
            .hit(mem_hit[gi]),
            .offset(mem_ofs[gi])
         ); // see RULE10
      end
      for (gi = 0; gi < NUM_AFE; gi++) begin : g_afe
         assign afe_hit[gi] = (cpu_addr[31:20] == 12'h000) && (cpu_addr[15:8] == 8'h00)
            && (cpu_addr[19:16] == 4'(gi + 2)); // see RULE5
      end
      for (gi = 0; gi < NUM_PER; gi++) begin : g_per
         assign per_hit[gi] = (cpu_addr[31:13] == `BMMD_SYSPER_HI) && (cpu_addr[12:10] == 3'(gi)); // see RULE13
      end
   endgenerate

   assign dec_hit = cpu_addr[31:8] == `BMMD_DEC_WIN;
   assign service = boot_state == bmmd_pkg::BS_SERVICE;

   // fixed priority ram, data flash, program flash, rom: the reset map has no overlap,
   // but where programmed regions overlap, the array first in this order wins
   always_comb begin
      mem_win = 4'h0;
      win_ofs = 24'h0;
      if (mem_hit[`BMMD_MEM_RAM]) begin
         mem_win[`BMMD_MEM_RAM] = 1'b1;
         win_ofs = mem_ofs[`BMMD_MEM_RAM];
      end else if (mem_hit[`BMMD_MEM_DFLASH]) begin
         mem_win[`BMMD_MEM_DFLASH] = 1'b1;
         win_ofs = mem_ofs[`BMMD_MEM_DFLASH];
      end else if (mem_hit[`BMMD_MEM_PFLASH]) begin
         mem_win[`BMMD_MEM_PFLASH] = 1'b1;
         win_ofs = mem_ofs[`BMMD_MEM_PFLASH];
      end else if (mem_hit[`BMMD_MEM_ROM]) begin
         mem_win[`BMMD_MEM_ROM] = 1'b1;
         win_ofs = mem_ofs[`BMMD_MEM_ROM] & 24'(`BMMD_ROM_BYTES - 1); // see RULE2
      end
   end

   assign any_hit = dec_hit || (|mem_win) || (|afe_hit) || (|per_hit); // see RULE1
   // user accesses checked per region; rom service mode bypasses the check
   assign perm_bad = !cpu_priv && !service
      && ((|(mem_win & ~perm_reg[3:0])) || (((|afe_hit) || (|per_hit)) && !perm_reg[4])); // see RULE14 RULE9

   ////////////////////////////////////////////////////////////////////////////
   // access sequencer
   logic start;
   assign start = ce && (acc_reg == bmmd_pkg::AC_IDLE) && cpu_req;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_reg <= bmmd_pkg::AC_IDLE;
      end else if (ce) begin
         unique case (acc_reg)
            bmmd_pkg::AC_IDLE: begin
               if (cpu_req) begin
                  acc_reg <= bmmd_pkg::AC_ACCESS;
               end
            end
            bmmd_pkg::AC_ACCESS: begin
               // decoder registers and refused accesses spend exactly one wait cycle here
               if (acc_dec_reg || acc_err_reg || slave_ready || dflash_ecc_err) begin
                  acc_reg <= bmmd_pkg::AC_DONE; // see RULE11 RULE13
               end
            end
            bmmd_pkg::AC_DONE: acc_reg <= bmmd_pkg::AC_IDLE;
            default: acc_reg <= bmmd_pkg::AC_IDLE;
         endcase
      end
   end

   // decode is frozen at the start so a config write never alters a running access
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_mem_reg <= 4'h0;
         acc_afe_reg <= '0;
         acc_per_reg <= '0;
         acc_dec_reg <= 1'b0;
         acc_err_reg <= 1'b0;
         acc_we_reg <= 1'b0;
         acc_priv_reg <= 1'b0;
         acc_reg_ofs_reg <= 8'h00;
         slave_addr <= 24'h0;
         slave_we <= 1'b0;
         slave_wdata <= 32'h0;
      end else if (start) begin
         acc_err_reg <= !any_hit || perm_bad; // see RULE15 RULE20
         acc_mem_reg <= (any_hit && !perm_bad) ? mem_win : 4'h0;
         acc_afe_reg <= (any_hit && !perm_bad) ? afe_hit : '0;
         acc_per_reg <= (any_hit && !perm_bad) ? per_hit : '0;
         acc_dec_reg <= dec_hit;
         acc_we_reg <= cpu_we;
         acc_priv_reg <= cpu_priv;
         acc_reg_ofs_reg <= cpu_addr[7:0];
         slave_addr <= (dec_hit || (|afe_hit)) ? {16'h0, cpu_addr[7:0]}
            : ((|per_hit) ? {14'h0, cpu_addr[9:0]} : win_ofs); // see RULE5
         slave_we <= cpu_we;
         slave_wdata <= cpu_wdata;
      end
   end

   always_comb begin
      mem_sel = (acc_reg == bmmd_pkg::AC_ACCESS) ? acc_mem_reg : 4'h0;
      afe_sel = (acc_reg == bmmd_pkg::AC_ACCESS) ? acc_afe_reg : '0;
      per_sel = (acc_reg == bmmd_pkg::AC_ACCESS) ? acc_per_reg : '0;
      cpu_ready = acc_reg == bmmd_pkg::AC_DONE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault or reset
   logic fault_now;
   logic ecc_fault_reg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ecc_fault_reg <= 1'b0;
      end else if (ce && acc_reg == bmmd_pkg::AC_ACCESS) begin
         ecc_fault_reg <= dflash_ecc_err && acc_mem_reg[`BMMD_MEM_DFLASH]; // see RULE17
      end
   end

   assign fault_now = (acc_reg == bmmd_pkg::AC_DONE) && (acc_err_reg || ecc_fault_reg);
   assign cpu_abort = fault_now && !rstsel_reg; // see RULE15

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sys_reset_req <= 1'b0;
      end else if (ce) begin
         sys_reset_req <= fault_now && rstsel_reg; // see RULE15
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoder registers
   assign cfg_we = ce && (acc_reg == bmmd_pkg::AC_ACCESS) && acc_dec_reg && acc_we_reg && acc_priv_reg; // see RULE12
   assign verdict_we = cfg_we && (acc_reg_ofs_reg == `BMMD_OFS_VERDICT);

   bmmd_boot_seq u_boot (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .verdict_we(verdict_we),
      .verdict_pass(slave_wdata[0]),
      .boot_state(boot_state),
      .remap_pulse(remap_pulse)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         base_reg[`BMMD_MEM_PFLASH] <= 22'(`BMMD_PFL_BASE_BOOT >> 10); // see RULE3
         size_reg[`BMMD_MEM_PFLASH] <= `BMMD_SZ_32K; // see RULE16
         base_reg[`BMMD_MEM_DFLASH] <= 22'(`BMMD_DFL_BASE >> 10);
         size_reg[`BMMD_MEM_DFLASH] <= `BMMD_SZ_2K;
         base_reg[`BMMD_MEM_ROM] <= 22'(`BMMD_ROM_BASE_BOOT >> 10);
         size_reg[`BMMD_MEM_ROM] <= `BMMD_SZ_64K; // see RULE2 RULE19
         base_reg[`BMMD_MEM_RAM] <= 22'(`BMMD_RAM_BASE >> 10);
         size_reg[`BMMD_MEM_RAM] <= `BMMD_SZ_4K; // see RULE18
         remap_reg <= 1'b0;
      end else if (remap_pulse) begin
         base_reg[`BMMD_MEM_PFLASH] <= 22'(`BMMD_PFL_BASE_RUN >> 10); // see RULE4
         base_reg[`BMMD_MEM_ROM] <= 22'(`BMMD_ROM_BASE_RUN >> 10);
         size_reg[`BMMD_MEM_ROM] <= `BMMD_SZ_4K;
         remap_reg <= 1'b1;
      end else if (cfg_we && acc_reg_ofs_reg[7:4] == `BMMD_OFS_REGION >> 4 && acc_reg_ofs_reg[1:0] == 2'b00) begin
         base_reg[acc_reg_ofs_reg[3:2]] <= slave_wdata[31:10]; // see RULE10
         size_reg[acc_reg_ofs_reg[3:2]] <= slave_wdata[3:0];
      end else if (cfg_we && acc_reg_ofs_reg == `BMMD_OFS_CTRL) begin
         remap_reg <= slave_wdata[`BMMD_CTRL_REMAP];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rstsel_reg <= 1'b0;
         perm_reg <= `BMMD_PERM_RESET;
      end else if (cfg_we && acc_reg_ofs_reg == `BMMD_OFS_CTRL) begin
         rstsel_reg <= slave_wdata[`BMMD_CTRL_RSTSEL];
      end else if (cfg_we && acc_reg_ofs_reg == `BMMD_OFS_PERM) begin
         perm_reg <= slave_wdata[4:0]; // see RULE14
      end
   end

   // erase is only a request; the flash controller owns the timing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pflash_erase_req <= 1'b0;
         pflash_erase_all <= 1'b0;
         pflash_erase_page <= 5'h00;
      end else if (ce) begin
         pflash_erase_req <= cfg_we && (acc_reg_ofs_reg == `BMMD_OFS_ERASE); // see RULE16
         if (cfg_we && acc_reg_ofs_reg == `BMMD_OFS_ERASE) begin
            pflash_erase_all <= slave_wdata[`BMMD_ERASE_ALL];
            pflash_erase_page <= slave_wdata[`BMMD_ERASE_PAGE_LSB +: PAGE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data
   logic [31:0] reg_rdata;
   always_comb begin
      reg_rdata = 32'h0000_0000;
      if (acc_reg_ofs_reg == `BMMD_OFS_CTRL) begin
         reg_rdata = {30'h0, rstsel_reg, remap_reg};
      end else if (acc_reg_ofs_reg == `BMMD_OFS_STAT) begin
         reg_rdata = {28'h0, boot_state};
      end else if (acc_reg_ofs_reg == `BMMD_OFS_PERM) begin
         reg_rdata = {27'h0, perm_reg};
      end else if (acc_reg_ofs_reg[7:4] == `BMMD_OFS_REGION >> 4 && acc_reg_ofs_reg[1:0] == 2'b00) begin
         reg_rdata = {base_reg[acc_reg_ofs_reg[3:2]], 6'h0, size_reg[acc_reg_ofs_reg[3:2]]};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_rdata <= 32'h0000_0000;
      end else if (ce && acc_reg == bmmd_pkg::AC_ACCESS) begin
         cpu_rdata <= acc_err_reg ? 32'h0000_0000 : (acc_dec_reg ? reg_rdata : slave_rdata);
      end
   end

   assign remap = remap_reg;
   assign boot_service = service;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_rom_alias_low : assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
      (start && !remap_reg && cpu_addr[31:16] == 16'h0000 && cpu_priv) |=> acc_mem_reg == 4'b0100)
      else $error("low 64 KB not decoded to rom before remap");
   a_boot_map_ram : assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
      (start && cpu_addr[31:12] == 20'h0_0019 && cpu_priv) |=> acc_mem_reg == 4'b1000)
      else $error("ram window not decoded");
   a_remap_flash_zero : assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
      remap_pulse |=> remap_reg && base_reg[0] == 22'h0 && base_reg[2] == 22'h40)
      else $error("remap did not move flash and rom");
   a_dec_wait_state : assert property (@(posedge clk) disable iff (sys_rst || !ce) // see RULE11
      (start && dec_hit) |-> !cpu_ready ##1 !cpu_ready ##1 cpu_ready)
      else $error("decoder register access lacks its wait state");
   a_user_write_ignored : assert property (@(posedge clk) disable iff (sys_rst) // see RULE12
      (acc_reg == bmmd_pkg::AC_ACCESS && acc_dec_reg && !acc_priv_reg) |=> $stable(perm_reg) && $stable(rstsel_reg))
      else $error("user write reached decoder registers");
   a_per_stretch : assert property (@(posedge clk) disable iff (sys_rst || !ce) // see RULE13
      (acc_reg == bmmd_pkg::AC_ACCESS && !acc_dec_reg && !acc_err_reg && !slave_ready && !dflash_ecc_err)
      |=> acc_reg == bmmd_pkg::AC_ACCESS && $stable(per_sel))
      else $error("slave cycle not stretched");
   a_illegal_fault : assert property (@(posedge clk) disable iff (sys_rst || !ce) // see RULE15
      (start && !any_hit) |-> ##2 (cpu_ready && (cpu_abort || rstsel_reg)))
      else $error("illegal address not faulted");
   a_afe_onehot : assert property (@(posedge clk) disable iff (sys_rst) // see RULE5
      $onehot0(afe_sel) && $onehot0(per_sel) && $onehot0(mem_sel))
      else $error("more than one select active");
   a_sel_frozen : assert property (@(posedge clk) disable iff (sys_rst) // see RULE20
      (acc_reg == bmmd_pkg::AC_ACCESS && $past(acc_reg) == bmmd_pkg::AC_ACCESS) |-> $stable(mem_sel))
      else $error("select changed during an access");
   a_service_any : assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
      (start && service && any_hit) |=> !acc_err_reg)
      else $error("service mode access refused");

   c_remap : cover property (@(posedge clk) disable iff (sys_rst) remap_pulse);
   c_dec_read : cover property (@(posedge clk) disable iff (sys_rst) cpu_ready && acc_dec_reg && !acc_we_reg);
   c_fault : cover property (@(posedge clk) disable iff (sys_rst) cpu_abort);
   c_per_stretch : cover property (@(posedge clk) disable iff (sys_rst) (|per_sel) ##1 (|per_sel) ##1 cpu_ready);
endmodule : bmmd_decoder

/* File: tb/bmmd_slave_model.sv */
`timescale 1ns/1ps
module bmmd_slave_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // selects from the decoder
   input wire logic any_sel,
   input wire logic dfl_sel,
   input wire logic [23:0] slave_addr,
   // test controls
   input wire logic [3:0] delay,
   input wire logic ecc_fail,
   // answer
   output logic slave_ready,
   output logic [31:0] slave_rdata,
   output logic dflash_ecc_err
);
   logic [3:0] cnt_reg;
   logic [31:0] last_reg;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 4'h0;
         last_reg <= 32'h0000_0000;
      end else begin
         cnt_reg <= any_sel ? cnt_reg + 4'h1 : 4'h0;
         last_reg <= slave_rdata;
      end
   end
   assign slave_ready = any_sel && !ecc_fail && cnt_reg >= delay;
   assign dflash_ecc_err = dfl_sel && ecc_fail && cnt_reg >= delay;
   // stale data is inverted so a late capture never matches by luck
   assign slave_rdata = slave_ready ? {8'hA5, slave_addr} : ~last_reg;
endmodule : bmmd_slave_model

/* File: tb/test_boot_memory_map_decoder.sv */
`timescale 1ns/1ps
module test_boot_memory_map_decoder;
   logic clk = 1'b0, sys_rst = 1'b1, cpu_req = 1'b0, cpu_we = 1'b0, cpu_priv = 1'b1, ecc = 1'b0, ce = 1'b1;
   logic er_req, er_all;
   logic [4:0] er_page;
   logic [31:0] cpu_addr = 32'h0000_0000, cpu_wdata = 32'h0000_0000, cpu_rdata, slave_rdata, slave_wdata, rd, sv;
   logic [3:0] mem_sel, dly = 4'h0;
   logic [12:0] afe_sel;
   logic [7:0] per_sel;
   logic [23:0] slave_addr, sa;
   logic cpu_ready, cpu_abort, slave_we, slave_ready, dflash_ecc_err, sys_reset_req, remap, boot_service, ab;
   int err_count = 0, compares = 0, n, cyc = 0;
   localparam logic [31:0] DEC = 32'hFFFF_FE00;
   always #2.5 clk = ~clk;
   bmmd_decoder dut_u (.clk, .sys_rst, .ce, .cpu_req, .cpu_we, .cpu_priv, .cpu_addr, .cpu_wdata,
      .cpu_rdata, .cpu_ready, .cpu_abort, .mem_sel, .afe_sel, .per_sel, .slave_addr, .slave_we, .slave_wdata,
      .slave_ready, .slave_rdata, .dflash_ecc_err, .pflash_erase_req(er_req), .pflash_erase_all(er_all),
      .pflash_erase_page(er_page), .sys_reset_req, .remap, .boot_service);
   bmmd_slave_model slv_u (.clk, .sys_rst, .any_sel(|{mem_sel, afe_sel, per_sel}), .dfl_sel(mem_sel[1]),
      .slave_addr, .delay(dly), .ecc_fail(ecc), .slave_ready, .slave_rdata, .dflash_ecc_err);
   ////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("mismatches=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task chk(input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one whole bus access; selects are sampled in the first access cycle
   task acc(input logic w, p, input logic [31:0] a, d);
      @(negedge clk);
      cpu_req = 1'b1;
      cpu_we = w;
      cpu_priv = p;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge clk);
      n = 1;
      sv = {7'h00, per_sel, afe_sel, mem_sel};
      sa = slave_addr;
      while (cpu_ready !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      rd = cpu_rdata;
      ab = cpu_abort;
      cpu_req = 1'b0;
   endtask : acc
   task rdx(input logic [31:0] a, s, input logic [23:0] o);
      acc(1'b0, 1'b1, a, 32'h0000_0000);
      chk(sv, s);
      chk({8'h00, sa}, {8'h00, o});
      chk(rd, {8'hA5, o});
   endtask : rdx
   task ill(input logic [31:0] a, input logic e);
      acc(1'b0, 1'b1, a, 32'h0000_0000);
      chk(sv, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk({31'h0, ab}, {31'h0, e});
   endtask : ill
   ////////////////////////////////////////////////////////////////
   task t_map;
      chk({remap, boot_service, cpu_ready, mem_sel}, 32'h0000_0000);
      rdx(32'h0000_F010, 32'h0000_0004, 24'h00_0010);
      rdx(32'h0000_0FFC, 32'h0000_0004, 24'h00_0FFC);
      rdx(32'h0001_0004, 32'h0000_0001, 24'h00_0004);
      rdx(32'h0001_8804, 32'h0000_0002, 24'h00_0004);
      rdx(32'h0001_9FFC, 32'h0000_0008, 24'h00_0FFC);
   endtask : t_map
   task t_periph;
      rdx(32'h0002_0010, 32'h0000_0010, 24'h00_0010);
      rdx(32'h000E_00FC, 32'h0001_0000, 24'h00_00FC);
      dly = 4'h3;
      rdx(32'hFFF7_EC04, 32'h0010_0000, 24'h00_0004);
      chk(n, 32'h0000_0005);
      dly = 4'h0;
      ill(32'h0002_0100, 1'b1);
      ill(32'hFFFF_FD00, 1'b1);
   endtask : t_periph
   task t_dec;
      acc(1'b0, 1'b1, DEC + 32'h0000_0004, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      chk(n, 32'h0000_0002);
      acc(1'b1, 1'b0, DEC, 32'h0000_0001);
      acc(1'b0, 1'b1, DEC, 32'h0000_0000);
      chk({remap, rd[0]}, 32'h0000_0000);
      acc(1'b1, 1'b1, DEC + 32'h0000_000C, 32'h0000_0017);
      acc(1'b0, 1'b0, 32'h0001_9000, 32'h0000_0000);
      chk({sv[3:0], ab}, 32'h0000_0001);
      rdx(32'h0001_9000, 32'h0000_0008, 24'h00_0000);
      acc(1'b1, 1'b1, DEC + 32'h0000_000C, 32'h0000_001F);
      ecc = 1'b1;
      acc(1'b0, 1'b1, 32'h0001_8800, 32'h0000_0000);
      chk({31'h0, ab}, 32'h0000_0001);
      ecc = 1'b0;
      acc(1'b1, 1'b1, DEC + 32'h0000_0010, 32'h0000_0701);
      chk(slave_wdata, 32'h0000_0701);
      chk({31'h0, slave_we}, 32'h0000_0001);
      chk({24'h0, er_req, er_all, er_page}, 32'h0000_0067);
      @(negedge clk);
      chk({24'h0, er_req, er_all, er_page}, 32'h0000_0027);
      acc(1'b1, 1'b1, DEC, 32'h0000_0002);
      ill(32'hFFFF_FD00, 1'b0);
      @(negedge clk);
      chk({31'h0, sys_reset_req}, 32'h0000_0001);
      acc(1'b1, 1'b1, DEC, 32'h0000_0000);
   endtask : t_dec
   task verdict(input logic p, input logic [31:0] st);
      acc(1'b1, 1'b1, DEC + 32'h0000_0008, {31'h0, p});
      acc(1'b0, 1'b1, DEC + 32'h0000_0004, 32'h0000_0000);
      chk(rd, st);
   endtask : verdict
   task t_boot;
      verdict(1'b0, 32'h0000_0002);
      verdict(1'b1, 32'h0000_0004);
      chk({31'h0, remap}, 32'h0000_0001);
      rdx(32'h0000_7FFC, 32'h0000_0001, 24'h00_7FFC);
      rdx(32'h0001_0010, 32'h0000_0004, 24'h00_0010);
      rdx(32'h0001_9004, 32'h0000_0008, 24'h00_0004);
      acc(1'b1, 1'b1, DEC + 32'h0000_002C, 32'h0003_8002);
      rdx(32'h0003_8004, 32'h0000_0008, 24'h00_0004);
   endtask : t_boot
   task t_service;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk({31'h0, remap}, 32'h0000_0000);
      verdict(1'b0, 32'h0000_0002);
      verdict(1'b0, 32'h0000_0008);
      chk({31'h0, boot_service}, 32'h0000_0001);
      acc(1'b1, 1'b1, DEC + 32'h0000_000C, 32'h0000_0000);
      acc(1'b0, 1'b0, 32'h0001_9000, 32'h0000_0000);
      chk({sv[3:0], ab}, 32'h0000_0010);
   endtask : t_service
   // clock enable low: a request must not be taken, state must resume afterwards
   task t_ce;
      @(negedge clk);
      ce = 1'b0;
      acc(1'b0, 1'b1, DEC + 32'h0000_0004, 32'h0000_0000);
      chk(n, 32'h0000_0028);
      chk(sv, 32'h0000_0000);
      ce = 1'b1;
      acc(1'b0, 1'b1, DEC + 32'h0000_0004, 32'h0000_0000);
      chk(rd, 32'h0000_0008);
      chk(n, 32'h0000_0002);
   endtask : t_ce
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      t_map();
      t_periph();
      t_dec();
      t_boot();
      t_service();
      t_ce();
      tally_and_finish();
   end
endmodule : test_boot_memory_map_decoder
